// file: temp_sensor_pkg.sv
// constants and types shared by the temperature sensor readout
`default_nettype none
package temp_sensor_pkg;

  // ***************
  // register offsets
  // ***************
  localparam logic [7:0] REG_LOCAL_TEMPERATURE           = 8'h00;
  localparam logic [7:0] REG_REMOTE_TEMPERATURE          = 8'h01;
  localparam logic [7:0] REG_STATUS                      = 8'h02;
  localparam logic [7:0] REG_CONFIG_READ                 = 8'h03;
  localparam logic [7:0] REG_RATE_READ                   = 8'h04;
  localparam logic [7:0] REG_CONFIG_WRITE                = 8'h09;
  localparam logic [7:0] REG_RATE_WRITE                  = 8'h0a;
  localparam logic [7:0] REG_SINGLE_CONVERSION_TRIGGER   = 8'h0f;
  localparam logic [7:0] REG_REMOTE_TEMPERATURE_FRACTION = 8'h10;
  localparam logic [7:0] REG_LOCAL_TEMPERATURE_FRACTION  = 8'h11;

  // ***************
  // fields and reset values
  // ***************
  localparam int         HALT_BIT         = 6;
  localparam int         BUSY_BIT         = 7;
  localparam logic [7:0] CONFIG_RESET     = 8'h20;
  localparam logic [7:0] RATE_RESET       = 8'h08;
  localparam logic [7:0] RATE_MAX         = 8'h08;
  localparam logic [7:0] RATE_EXT_MAX     = 8'h06;
  localparam logic [7:0] RESULT_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h4c;

  // ***************
  // timing
  // ***************
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned CHANNEL_TIME_MS   = 60;
  localparam int unsigned SLOWEST_PERIOD_S  = 16;
  localparam int unsigned CONV_CYCLES       = 2 * (CLK_HZ / 1000) * CHANNEL_TIME_MS;
  localparam int unsigned SLOW_PERIOD_CYCLES = SLOWEST_PERIOD_S * CLK_HZ;

  typedef struct packed {
    logic [7:0] whole;
    logic [2:0] fraction;
  } temp_result_s;

endpackage : temp_sensor_pkg
`default_nettype wire

// file: sync_2ff.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // pins idle high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync_2ff
`default_nettype wire

// file: conversion_timer.sv
// conversion sequence timer with abort
`default_nettype none
module conversion_timer #(
  parameter int unsigned CYCLES = 100
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  int unsigned count;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= 0;
    end else begin
      done <= 1'b0;
      if (busy && abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1;
        end
      end else if (start) begin
        busy  <= 1'b1;
        count <= CYCLES;
      end
    end
  end
endmodule : conversion_timer
`default_nettype wire

// file: temp_sensor_smbus_readout.sv
// two-wire slave and conversion control of a two-channel temperature sensor
//
// Operation
// - halt bit 6 set enters software standby
// - standby pin low forces hardware standby
// - standby keeps registers and bus responsive
// - one-shot in software standby converts once
// - hardware standby ignores one-shot requests
// - standby pin overrides all software conversion
// - standby during conversion aborts, results kept
// - 8-bit registers under one slave address
// - write, read, send, receive byte formats
// - pointer persists for receive byte
// - results 00h/01h two's complement 1C
// - data bytes shifted out msb first
// - fraction bits at 10h/11h, slow rates
// - main and fraction updated together
// - command 0fh triggers one-shot conversion
// - busy bit reads 1 during conversion
// - reset sets rate code to 16Hz
// - software standby disables converter except one-shot
// - halt clear converts both channels continuously
// - reads during conversion return previous results
`default_nettype none
module temp_sensor_smbus_readout #(
  parameter int unsigned CONV_CYCLES        = temp_sensor_pkg::CONV_CYCLES,
  parameter int unsigned SLOW_PERIOD_CYCLES = temp_sensor_pkg::SLOW_PERIOD_CYCLES,
  parameter logic [6:0]  SLAVE_ADDR         = temp_sensor_pkg::SLAVE_ADDR_RESET
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_n,
  input  wire logic                         standby_pin_n,
  input  wire temp_sensor_pkg::temp_result_s local_sample,
  input  wire temp_sensor_pkg::temp_result_s remote_sample,
  output logic                              converter_enable
);
  import temp_sensor_pkg::*;

  // ***************
  // types and signals
  // ***************
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } bus_state_e;

  bus_state_e   bus_state;
  logic [2:0]   pins_s;
  logic         scl_s;
  logic         sda_s;
  logic         standby_s_n;
  logic         scl_d;
  logic         sda_d;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;
  logic [3:0]   bit_cnt;
  logic [7:0]   shift_in;
  logic [7:0]   tx_byte;
  logic         drive_low;
  logic         rw_bit;
  logic         host_ack;
  logic [7:0]   pointer;
  logic [7:0]   read_data;
  logic         cmd_done;
  logic         wr_done;
  logic [7:0]   config_reg;
  logic [7:0]   rate;
  temp_result_s local_result;
  temp_result_s remote_result;
  logic         hw_standby;
  logic         halt;
  logic         halt_write;
  logic         oneshot_req;
  logic         oneshot_pending;
  logic         start_conv;
  logic         abort_conv;
  logic         busy;
  logic         done;
  logic         ext_valid;
  int unsigned  interval_cnt;
  int unsigned  interval;
  logic [7:0]   rate_code;

  // ***************
  // pin synchronisers
  // ***************
  sync_2ff #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({scl_in, sda_in, standby_pin_n}),
    .q       (pins_s)
  );

  assign scl_s       = pins_s[2];
  assign sda_s       = pins_s[1];
  assign standby_s_n = pins_s[0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // open drain: only ever pull low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;

  // ***************
  // bus byte events
  // ***************
  assign cmd_done    = (bus_state == ST_CMD) && scl_fall && (bit_cnt == 4'h8);
  assign wr_done     = (bus_state == ST_WDATA) && scl_fall && (bit_cnt == 4'h8);
  assign halt_write  = wr_done && (pointer == REG_CONFIG_WRITE) && shift_in[HALT_BIT];
  assign oneshot_req = cmd_done && (shift_in == REG_SINGLE_CONVERSION_TRIGGER);

  // ***************
  // read multiplexer
  // ***************
  always_comb begin
    case (pointer)
      REG_LOCAL_TEMPERATURE:           read_data = local_result.whole;
      REG_REMOTE_TEMPERATURE:          read_data = remote_result.whole;
      REG_STATUS:                      read_data = {busy, 7'h00};
      REG_CONFIG_READ:                 read_data = config_reg;
      REG_RATE_READ:                   read_data = rate;
      REG_REMOTE_TEMPERATURE_FRACTION: read_data = {remote_result.fraction, 5'h00};
      REG_LOCAL_TEMPERATURE_FRACTION:  read_data = {local_result.fraction, 5'h00};
      default:                         read_data = UNMAPPED_READ;
    endcase
  end

  // ***************
  // slave state machine
  // ***************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_state <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift_in  <= 8'h00;
      tx_byte   <= 8'h00;
      drive_low <= 1'b0;
      rw_bit    <= 1'b0;
      host_ack  <= 1'b0;
    end else if (start_cond) begin
      bus_state <= ST_ADDR;
      bit_cnt   <= 4'h0;
      drive_low <= 1'b0;
    end else if (stop_cond) begin
      bus_state <= ST_IDLE;
      drive_low <= 1'b0;
    end else begin
      case (bus_state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            shift_in <= {shift_in[6:0], sda_s};
            bit_cnt  <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (bus_state == ST_ADDR) begin
              if (shift_in[7:1] == SLAVE_ADDR) begin
                rw_bit    <= shift_in[0];
                drive_low <= 1'b1;
                bus_state <= ST_ADDR_ACK;
              end else begin
                bus_state <= ST_IDLE;
              end
            end else if (bus_state == ST_CMD) begin
              drive_low <= 1'b1;
              bus_state <= ST_CMD_ACK;
            end else begin
              drive_low <= 1'b1;
              bus_state <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_bit) begin
              // first read bit, msb first
              drive_low <= ~read_data[7];
              tx_byte   <= {read_data[6:0], 1'b0};
              bit_cnt   <= 4'h1;
              bus_state <= ST_RDATA;
            end else begin
              drive_low <= 1'b0;
              bus_state <= ST_CMD;
            end
          end
        end
        ST_CMD_ACK: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            bus_state <= ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            bus_state <= ST_IDLE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              drive_low <= 1'b0;
              bus_state <= ST_RDATA_ACK;
            end else begin
              drive_low <= ~tx_byte[7];
              tx_byte   <= {tx_byte[6:0], 1'b0};
              bit_cnt   <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            host_ack <= ~sda_s;
          end else if (scl_fall) begin
            if (host_ack) begin
              drive_low <= ~read_data[7];
              tx_byte   <= {read_data[6:0], 1'b0};
              bit_cnt   <= 4'h1;
              bus_state <= ST_RDATA;
            end else begin
              bus_state <= ST_IDLE;
            end
          end
        end
        default: begin
          bus_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************
  // pointer and control registers
  // ***************
  // bus logic never looks at standby
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pointer <= 8'h00;
    end else if (cmd_done) begin
      pointer <= shift_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_reg <= CONFIG_RESET;
      rate       <= RATE_RESET;
    end else if (wr_done) begin
      if (pointer == REG_CONFIG_WRITE) begin
        config_reg <= shift_in;
      end
      if (pointer == REG_RATE_WRITE) begin
        rate <= shift_in;
      end
    end
  end

  // ***************
  // conversion control
  // ***************
  assign hw_standby = ~standby_s_n;
  assign halt       = config_reg[HALT_BIT];
  assign rate_code  = (rate > RATE_MAX) ? RATE_MAX : rate;
  assign interval   = SLOW_PERIOD_CYCLES >> rate_code;
  assign ext_valid  = (rate_code <= RATE_EXT_MAX);

  // hardware standby gates every start
  assign start_conv = ~busy && ~hw_standby &&
                      ((~halt && interval_cnt == 0) || oneshot_pending);
  assign abort_conv = busy && (hw_standby || halt_write);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oneshot_pending <= 1'b0;
    end else if (hw_standby) begin
      oneshot_pending <= 1'b0;
    end else if (oneshot_req) begin
      oneshot_pending <= 1'b1;
    end else if (start_conv) begin
      oneshot_pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      interval_cnt <= 0;
    end else if (halt || hw_standby) begin
      interval_cnt <= 0;
    end else if (start_conv) begin
      interval_cnt <= (interval > 1) ? interval - 1 : 0;
    end else if (interval_cnt != 0) begin
      interval_cnt <= interval_cnt - 1;
    end
  end

  conversion_timer #(
    .CYCLES (CONV_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (start_conv),
    .abort   (abort_conv),
    .busy    (busy),
    .done    (done)
  );

  assign converter_enable = busy;

  // ***************
  // result registers
  // ***************
  // results change only at done, so reads in flight see old data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_result  <= '{whole: RESULT_RESET, fraction: 3'h0};
      remote_result <= '{whole: RESULT_RESET, fraction: 3'h0};
    end else if (done) begin
      local_result.whole     <= local_sample.whole;
      remote_result.whole    <= remote_sample.whole;
      local_result.fraction  <= ext_valid ? local_sample.fraction : 3'h0;
      remote_result.fraction <= ext_valid ? remote_sample.fraction : 3'h0;
    end
  end

endmodule : temp_sensor_smbus_readout
`default_nettype wire

// file: temp_sensor_smbus_readout_properties.sv
// pin-level checks of the sensor readout block
`default_nettype none
module temp_sensor_smbus_readout_properties #(
  parameter int unsigned CONV_CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic standby_pin_n,
  input wire logic converter_enable
);
  // ***************
  // helper logic
  // ***************
  int unsigned run_len;

  // length of the running conversion
  always_ff @(posedge ref_clk) begin
    if (reset || !converter_enable) begin
      run_len <= 0;
    end else begin
      run_len <= run_len + 1;
    end
  end

  // ***************
  // assertions
  // ***************
  AST_SDA_OUT_LOW: assert property (
    @(posedge ref_clk) sda_out == 1'b0)
    else $error("sda_out not held low");
  AST_RESET_QUIET: assert property (
    @(posedge ref_clk) reset |=> sda_oe_n && !converter_enable)
    else $error("outputs active in reset");
  AST_FREE_RUN: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) && standby_pin_n |-> ##[1:8] converter_enable)
    else $error("no conversion after reset");
  AST_PIN_ABORT: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(standby_pin_n) && converter_enable |-> ##[1:6] !converter_enable)
    else $error("conversion not aborted by pin");
  AST_PIN_NO_START: assert property (
    @(posedge ref_clk) disable iff (reset)
    !standby_pin_n [*6] |-> !$rose(converter_enable))
    else $error("conversion started in standby");
  AST_SDA_STABLE: assert property (
    @(posedge ref_clk) disable iff (reset)
    scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda changed while scl high");
  AST_IDLE_RELEASE: assert property (
    @(posedge ref_clk) disable iff (reset)
    scl_in [*8] |-> sda_oe_n)
    else $error("sda held with scl idle");
  AST_CONV_BOUND: assert property (
    @(posedge ref_clk) disable iff (reset)
    converter_enable |-> run_len <= CONV_CYCLES)
    else $error("conversion too long");
endmodule : temp_sensor_smbus_readout_properties

bind temp_sensor_smbus_readout temp_sensor_smbus_readout_properties #(
  .CONV_CYCLES(CONV_CYCLES)
) u_props (
  .ref_clk         (ref_clk),
  .reset           (reset),
  .scl_in          (scl_in),
  .sda_out         (sda_out),
  .sda_oe_n        (sda_oe_n),
  .standby_pin_n   (standby_pin_n),
  .converter_enable(converter_enable)
);
`default_nettype wire

// file: smbus_host_model.sv
// two-wire host master driving the sensor bus
`default_nettype none
module smbus_host_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] addr = 7'h4c;
  logic       acked = 1'b1;

  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // bit out, sda moves only while scl low
  task automatic put(input logic b);
    tick(3);
    sda_m <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask : put

  task automatic get(output logic b);
    tick(3);
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    b = sda;
    tick(1);
    scl <= 1'b0;
  endtask : get

  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    acked &= !a;
  endtask : put_byte

  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
  endtask : get_byte

  task automatic start();
    tick(4);
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    tick(4);
    sda_m <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(4);
  endtask : stop

  // kind 0 write, 1 read, 2 send, 3 receive; sole master on the bus
  task automatic xfer(input logic [1:0] kind, input logic [7:0] cmd, inout logic [7:0] d);
    start();
    acked = 1'b1;
    if (kind != 2'd3) begin
      put_byte({addr, 1'b0});
      put_byte(cmd);
    end
    if (kind == 2'd0) put_byte(d);
    if (kind == 2'd1) start();
    if (kind[0]) begin
      put_byte({addr, 1'b1});
      get_byte(d);
    end
    stop();
  endtask : xfer
endmodule : smbus_host_model
`default_nettype wire

// file: testbench.sv
// self-checking bench of the sensor readout block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import temp_sensor_pkg::*;
  logic         ref_clk = 1'b0;
  logic         reset = 1'b1;
  logic         standby_pin_n = 1'b1;
  temp_result_s loc = '0;
  temp_result_s rem = '0;
  logic         scl;
  logic         sda_m;
  logic         sda_out;
  logic         sda_oe_n;
  logic         conv_on;
  logic [7:0]   q;
  int           err_total = 0;
  int           n_compared = 0;
  int           cycles = 0;
  wire logic    sda = sda_m & (sda_oe_n | sda_out);

  always #50 ref_clk = ~ref_clk;

  temp_sensor_smbus_readout #(
    .CONV_CYCLES(2000),
    .SLOW_PERIOD_CYCLES(4096)
  ) u_temp_sensor_smbus_readout (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .standby_pin_n(standby_pin_n),
    .local_sample(loc), .remote_sample(rem), .converter_enable(conv_on)
  );

  smbus_host_model host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic rd(input logic [1:0] k, input logic [7:0] c, input logic [7:0] exp);
    q = 8'h00;
    host.xfer(k, c, q);
    check_bit(host.acked, 1'b1);
    check_byte(q, exp);
  endtask : rd

  task automatic wr(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
    q = d;
    host.xfer(k, c, q);
    check_bit(host.acked, 1'b1);
  endtask : wr

  // bounded wait for a converter level
  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (conv_on !== lvl && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    check_bit(conv_on, lvl);
  endtask : wait_lvl

  task automatic quiet(input int cyc);
    int on;
    on = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (conv_on !== 1'b0) on++;
    end
    check_bit(on == 0, 1'b1);
  endtask : quiet

  // ***************
  // scenarios
  // ***************
  task automatic reset_values();
    rd(2'd1, REG_CONFIG_READ, CONFIG_RESET);
    rd(2'd1, REG_RATE_READ, RATE_RESET);
    rd(2'd1, REG_STATUS, 8'h80);
    rd(2'd1, REG_LOCAL_TEMPERATURE, RESULT_RESET);
  endtask : reset_values

  task automatic results();
    loc <= '{8'h19, 3'b101};
    rem <= '{8'he7, 3'b011};
    wait_lvl(1'b0);
    rd(2'd1, REG_LOCAL_TEMPERATURE, 8'h19);
    rd(2'd1, REG_REMOTE_TEMPERATURE, 8'he7);
    rd(2'd1, REG_LOCAL_TEMPERATURE_FRACTION, 8'h00);
    wr(2'd0, REG_LOCAL_TEMPERATURE, 8'h55);
    rd(2'd1, REG_LOCAL_TEMPERATURE, 8'h19);
    wr(2'd0, REG_RATE_WRITE, 8'h04);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    rd(2'd1, REG_LOCAL_TEMPERATURE_FRACTION, 8'ha0);
    rd(2'd3, 8'h00, 8'ha0);
    rd(2'd1, REG_REMOTE_TEMPERATURE_FRACTION, 8'h60);
    wr(2'd2, REG_REMOTE_TEMPERATURE, 8'h00);
    rd(2'd3, 8'h00, 8'he7);
  endtask : results

  task automatic sw_standby();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    loc <= '{8'h7f, 3'b111};
    wr(2'd0, REG_CONFIG_WRITE, 8'h60);
    quiet(3000);
    rd(2'd1, REG_LOCAL_TEMPERATURE, 8'h19);
    rd(2'd1, REG_STATUS, 8'h00);
    wr(2'd2, REG_SINGLE_CONVERSION_TRIGGER, 8'h00);
    check_bit(conv_on, 1'b1);
    rd(2'd3, 8'h00, UNMAPPED_READ);
    wait_lvl(1'b0);
    quiet(3000);
    rd(2'd1, REG_LOCAL_TEMPERATURE, 8'h7f);
    rd(2'd1, REG_LOCAL_TEMPERATURE_FRACTION, 8'he0);
  endtask : sw_standby

  task automatic hw_standby();
    wr(2'd0, REG_CONFIG_WRITE, 8'h20);
    wait_lvl(1'b1);
    rem <= '{8'h80, 3'b000};
    standby_pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check_bit(conv_on, 1'b0);
    rd(2'd1, REG_REMOTE_TEMPERATURE, 8'he7);
    wr(2'd2, REG_SINGLE_CONVERSION_TRIGGER, 8'h00);
    quiet(3000);
    rd(2'd1, REG_CONFIG_READ, 8'h20);
    standby_pin_n <= 1'b1;
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    rd(2'd1, REG_REMOTE_TEMPERATURE, 8'h80);
  endtask : hw_standby

  task automatic wrong_address();
    host.addr = SLAVE_ADDR_RESET ^ 7'h01;
    q = 8'h00;
    host.xfer(2'd3, 8'h00, q);
    check_bit(host.acked, 1'b0);
    check_byte(q, 8'hff);
    host.addr = SLAVE_ADDR_RESET;
  endtask : wrong_address

  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_values();
    results();
    sw_standby();
    hw_standby();
    wrong_address();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
